/* File: logic/iopc_pkg.sv */
// Package for the upper-port pin control block: offsets, layouts, reset values
package iopc_pkg;

  // Register byte offsets on the Wishbone slave (word aligned)
  localparam logic [7:0] P9_DATA_OFS   = 8'h00;
  localparam logic [7:0] P9_DIR_OFS    = 8'h04;
  localparam logic [7:0] P9_ALT_OFS    = 8'h08;
  localparam logic [7:0] P10_DATA_OFS  = 8'h0C;
  localparam logic [7:0] P10_DIR_OFS   = 8'h10;
  localparam logic [7:0] P10_ALT_OFS   = 8'h14;
  localparam logic [7:0] P11_DATA_OFS  = 8'h18;
  localparam logic [7:0] P11_DIR_OFS   = 8'h1C;
  localparam logic [7:0] P12_DATA_OFS  = 8'h20;
  localparam logic [7:0] P12_DIR_OFS   = 8'h24;
  localparam logic [7:0] PERIPH_CTL_OFS = 8'h28;

  // Widths and field positions
  localparam int          PORT_W       = 8;
  localparam int          P12_W        = 2;
  localparam int          GATE_LVL_BIT = 7;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

  // Port 10 bit classes for the secondary read path
  localparam logic [7:0]  P10_PERIPH_RD = 8'hA3; // Bits 0,1,5,7 read peripheral data
  localparam logic [7:0]  P10_PIN_RD    = 8'h0C; // Bits 2,3 read the pin
  localparam int          P10_TMR_BIT   = 4;
  localparam int          P10_EXP_BIT   = 6;

  // Peripheral-facing signals of one 8-bit port
  typedef struct packed {
    logic [7:0] out_data; // Peripheral drive value
    logic [7:0] out_en;   // Peripheral drives this bit
  } iopc_periph_t;

  // Two-signal pin group
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n; // Low while driving
  } iopc_pin_t;

endpackage : iopc_pkg

/* File: logic/iopc_top.sv */
// Upper I/O ports 9-12 with direction, alternate function, read-back and global gate
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

module iopc_top (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone classic slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Device pins
  input  wire logic [7:0]            p9_pin_i,
  input  wire logic [7:0]            p10_pin_i,
  input  wire logic [7:0]            p11_pin_i,
  input  wire logic [1:0]            p12_pin_i,
  output logic      [7:0]            p9_out_o,
  output logic      [7:0]            p9_oe_n_o,
  output logic      [7:0]            p10_out_o,
  output logic      [7:0]            p10_oe_n_o,
  output logic      [7:0]            p11_out_o,
  output logic      [7:0]            p11_oe_n_o,
  output logic      [1:0]            p12_out_o,
  output logic      [1:0]            p12_oe_n_o,
  input  wire logic                  driver_gate_n_i,
  input  wire logic                  external_fetch_select_n_i,
  input  wire logic                  wide_address_i,
  // Peripheral side
  input  wire iopc_pkg::iopc_periph_t p9_periph_i,
  input  wire iopc_pkg::iopc_periph_t p10_periph_i,
  input  wire iopc_pkg::iopc_periph_t p11_monitor_i,
  input  wire logic [1:0]            ext_addr_hi_i,
  input  wire logic                  capture_mode_i,
  input  wire logic                  expansion_out_mode_i,
  output logic      [7:0]            p9_in_o,
  output logic      [7:0]            p10_in_o,
  output logic                       p11_monitor_en_o
);

  // Register file
  // Every register is one byte in the low lane; port 12 keeps only two bits
  // Reset clears all of them, so ports 9 and 10 wake up as released inputs; 11 and 12 too unless the monitor or the address drive takes them
  logic [7:0] p9_data, p9_direction, port9_alt_function_select;
  logic [7:0] p10_data, p10_direction, port10_alt_function_select;
  logic [7:0] p11_data, port11_direction;
  logic [1:0] p12_data, port12_direction;
  logic [7:0] next_p9_data, next_p9_direction, next_port9_alt_function_select;
  logic [7:0] next_p10_data, next_p10_direction, next_port10_alt_function_select;
  logic [7:0] next_p11_data, next_port11_direction;
  logic [1:0] next_p12_data, next_port12_direction;

  // Bus answer registers
  // Ack is registered, so a request is answered one cycle after it is taken
  // Read data is registered with it and stands for that one cycle
  logic        next_ack;
  logic [31:0] next_dat;

  // Pin synchronisers; first stage is read only by the second
  // Pin levels, the gate and the fetch select are asynchronous to clk_i
  // Cost: a pin change reaches the read path two edges late
  logic [7:0] p9_s1, p9_s2, p10_s1, p10_s2, p11_s1, p11_s2;
  logic [1:0] p12_s1, p12_s2;
  logic       gate_s1, gate_s2, fetch_s1, fetch_s2;

  // Pin driver next values
  // Built combinationally here and registered once in the output stage
  iopc_pkg::iopc_pin_t next_p9_pin, next_p10_pin, next_p11_pin;
  logic [1:0] next_p12_out, next_p12_oe_n;
  logic [7:0] next_p9_in, next_p10_in;
  logic       next_mon_en;

  // Plain port read: pin for inputs, latch for outputs
  // Shared by all four ports, so one read rule serves every plain bit
  function automatic logic [7:0] plain_rd(input logic [7:0] dir, input logic [7:0] latch,
                                          input logic [7:0] pin);
    plain_rd = (dir & latch) | (~dir & pin);
  endfunction : plain_rd

  // Two-flop synchronisers on every pin input
  // No reset here: the flops settle on their own within two edges
  always_ff @(posedge clk_i) begin
    p9_s1    <= p9_pin_i;
    p9_s2    <= p9_s1;
    p10_s1   <= p10_pin_i;
    p10_s2   <= p10_s1;
    p11_s1   <= p11_pin_i;
    p11_s2   <= p11_s1;
    p12_s1   <= p12_pin_i;
    p12_s2   <= p12_s1;
    gate_s1  <= driver_gate_n_i;
    gate_s2  <= gate_s1;
    fetch_s1 <= external_fetch_select_n_i;
    fetch_s2 <= fetch_s1;
  end

  // Read-back values for each register
  logic [7:0] p9_rd, p10_rd, p11_rd, periph_ctl_rd;
  logic [1:0] p12_rd;
  logic [7:0] p12_rd_full; // Port 12 read widened to the shared byte rule
  logic       req;         // A new bus cycle that has not yet been answered

  always_comb begin
    p9_rd  = plain_rd(p9_direction, p9_data, p9_s2);
    // Alternate bits of port 9 are inputs or peripheral outputs; read as plain port
    p11_rd = plain_rd(port11_direction, p11_data, p11_s2);
    // Port 12 is padded to a byte for the shared rule, then cut back to two bits
    p12_rd_full = plain_rd({6'h00, port12_direction}, {6'h00, p12_data}, {6'h00, p12_s2});
    p12_rd      = p12_rd_full[1:0];
    p10_rd = plain_rd(p10_direction, p10_data, p10_s2);
    // Secondary read path of port 10
    // Each alternate bit picks pin or peripheral data by its class; rmw reads it too
    for (int i = 0; i < iopc_pkg::PORT_W; i++) begin
      if (port10_alt_function_select[i]) begin
        if (iopc_pkg::P10_PERIPH_RD[i]) begin
          p10_rd[i] = p10_periph_i.out_data[i];
        end else if (iopc_pkg::P10_PIN_RD[i]) begin
          p10_rd[i] = p10_s2[i];
        end else if (i == iopc_pkg::P10_TMR_BIT) begin
          p10_rd[i] = capture_mode_i ? p10_s2[i] : p10_periph_i.out_data[i];
        end else if (i == iopc_pkg::P10_EXP_BIT) begin
          // Expansion port in output mode hands back what it drives
          p10_rd[i] = expansion_out_mode_i ? p10_periph_i.out_data[i] : p10_s2[i];
        end
      end
    end
    // Only the gate level is visible; the other bits read zero
    periph_ctl_rd = 8'h00;
    periph_ctl_rd[iopc_pkg::GATE_LVL_BIT] = gate_s2;
  end

  // Register writes and Wishbone answer; ack one cycle after request, then drops
  // Masking with the own ack keeps a held strobe from being taken twice
  // Unmapped offsets are still acknowledged so the master never waits
  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_p9_data = p9_data;
    next_p9_direction = p9_direction;
    next_port9_alt_function_select = port9_alt_function_select;
    next_p10_data = p10_data;
    next_p10_direction = p10_direction;
    next_port10_alt_function_select = port10_alt_function_select;
    next_p11_data = p11_data;
    next_port11_direction = port11_direction;
    next_p12_data = p12_data;
    next_port12_direction = port12_direction;
    next_ack = req;
    next_dat = iopc_pkg::UNMAPPED_RD;
    // Writes always land in the latch, whatever direction says
    // Only byte lane 0 carries a register; other lanes are ignored
    if (req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == iopc_pkg::P9_DATA_OFS) begin
        next_p9_data = wb_dat_i[7:0];
      end else if (wb_adr_i == iopc_pkg::P9_DIR_OFS) begin
        next_p9_direction = wb_dat_i[7:0];
      end else if (wb_adr_i == iopc_pkg::P9_ALT_OFS) begin
        next_port9_alt_function_select = wb_dat_i[7:0];
      end else if (wb_adr_i == iopc_pkg::P10_DATA_OFS) begin
        next_p10_data = wb_dat_i[7:0];
      end else if (wb_adr_i == iopc_pkg::P10_DIR_OFS) begin
        next_p10_direction = wb_dat_i[7:0];
      end else if (wb_adr_i == iopc_pkg::P10_ALT_OFS) begin
        next_port10_alt_function_select = wb_dat_i[7:0];
      end else if (wb_adr_i == iopc_pkg::P11_DATA_OFS) begin
        next_p11_data = wb_dat_i[7:0];
      end else if (wb_adr_i == iopc_pkg::P11_DIR_OFS) begin
        next_port11_direction = wb_dat_i[7:0];
      end else if (wb_adr_i == iopc_pkg::P12_DATA_OFS) begin
        next_p12_data = wb_dat_i[1:0];
      end else if (wb_adr_i == iopc_pkg::P12_DIR_OFS) begin
        next_port12_direction = wb_dat_i[1:0];
      end
    end
    // Reads: unmapped or write cycles return zero
    // Read data is sampled at the taking edge and held one cycle with ack
    if (req && !wb_we_i) begin
      if (wb_adr_i == iopc_pkg::P9_DATA_OFS) begin
        next_dat = {24'h00_0000, p9_rd};
      end else if (wb_adr_i == iopc_pkg::P9_DIR_OFS) begin
        next_dat = {24'h00_0000, p9_direction};
      end else if (wb_adr_i == iopc_pkg::P9_ALT_OFS) begin
        next_dat = {24'h00_0000, port9_alt_function_select};
      end else if (wb_adr_i == iopc_pkg::P10_DATA_OFS) begin
        next_dat = {24'h00_0000, p10_rd};
      end else if (wb_adr_i == iopc_pkg::P10_DIR_OFS) begin
        next_dat = {24'h00_0000, p10_direction};
      end else if (wb_adr_i == iopc_pkg::P10_ALT_OFS) begin
        next_dat = {24'h00_0000, port10_alt_function_select};
      end else if (wb_adr_i == iopc_pkg::P11_DATA_OFS) begin
        next_dat = {24'h00_0000, p11_rd};
      end else if (wb_adr_i == iopc_pkg::P11_DIR_OFS) begin
        next_dat = {24'h00_0000, port11_direction};
      end else if (wb_adr_i == iopc_pkg::P12_DATA_OFS) begin
        next_dat = {30'h0000_0000, p12_rd};
      end else if (wb_adr_i == iopc_pkg::P12_DIR_OFS) begin
        next_dat = {30'h0000_0000, port12_direction};
      end else if (wb_adr_i == iopc_pkg::PERIPH_CTL_OFS) begin
        next_dat = {24'h00_0000, periph_ctl_rd};
      end
    end
  end

  // Pin drivers; computed from registers so outputs come straight from flops
  // Trade-off: one extra edge of latency from a register write to the pad
  always_comb begin
    // Port 9: alternate bits hand the driver to the peripheral
    // The peripheral's own enable decides the drive; direction is ignored
    for (int i = 0; i < iopc_pkg::PORT_W; i++) begin
      if (port9_alt_function_select[i]) begin
        next_p9_pin.out[i]  = p9_periph_i.out_data[i];
        next_p9_pin.oe_n[i] = ~p9_periph_i.out_en[i];
      end else begin
        next_p9_pin.out[i]  = p9_data[i];
        next_p9_pin.oe_n[i] = ~p9_direction[i];
      end
    end
    // Port 10: bits 0-4 are behind the global gate
    // Bits 5-7 are outside the gated set and ignore the gate
    for (int i = 0; i < iopc_pkg::PORT_W; i++) begin
      if (port10_alt_function_select[i]) begin
        next_p10_pin.out[i]  = p10_periph_i.out_data[i];
        next_p10_pin.oe_n[i] = ~p10_periph_i.out_en[i];
      end else begin
        next_p10_pin.out[i]  = p10_data[i];
        next_p10_pin.oe_n[i] = ~p10_direction[i];
      end
      // Gate only removes drive; inputs keep sampling the pin
      if (i <= iopc_pkg::P10_TMR_BIT && gate_s2) begin
        next_p10_pin.oe_n[i] = 1'b1;
      end
    end
    // Port 11: monitor owns the pins only with fetch select high
    // Monitor enable bits take the pin; the rest stay with the plain port
    next_mon_en = fetch_s2;
    if (fetch_s2) begin
      next_p11_pin.out  = (p11_monitor_i.out_en & p11_monitor_i.out_data)
                        | (~p11_monitor_i.out_en & p11_data);
      next_p11_pin.oe_n = ~(p11_monitor_i.out_en | port11_direction);
    end else begin
      next_p11_pin.out  = p11_data;
      next_p11_pin.oe_n = ~port11_direction;
    end
    // Port 12: address bits when fetching externally
    // Address drive overrides direction, but the global gate still wins
    next_p12_out  = p12_data;
    next_p12_oe_n = ~port12_direction;
    if (!fetch_s2) begin
      next_p12_out[0]  = ext_addr_hi_i[0];
      next_p12_oe_n[0] = 1'b0;
      if (wide_address_i) begin
        next_p12_out[1]  = ext_addr_hi_i[1];
        next_p12_oe_n[1] = 1'b0;
      end
    end
    if (gate_s2) begin
      next_p12_oe_n = 2'b11;
    end
    // Input paths to peripherals
    // Peripherals see the synchronised level whatever the direction says
    next_p9_in  = p9_s2;
    next_p10_in = p10_s2;
  end

  // Register stage: one synchronous reset clears everything
  // Every reset source arrives here as rst_i; the bus answer is cleared too
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p9_data                    <= iopc_pkg::REG_RESET;
      p9_direction               <= iopc_pkg::REG_RESET;
      port9_alt_function_select  <= iopc_pkg::REG_RESET;
      p10_data                   <= iopc_pkg::REG_RESET;
      p10_direction              <= iopc_pkg::REG_RESET;
      port10_alt_function_select <= iopc_pkg::REG_RESET;
      p11_data                   <= iopc_pkg::REG_RESET;
      port11_direction           <= iopc_pkg::REG_RESET;
      p12_data                   <= 2'b00;
      port12_direction           <= 2'b00;
      wb_ack_o                   <= 1'b0;
      wb_dat_o                   <= 32'h0000_0000;
      // All drivers released: high-impedance inputs
      // Out values are parked low so nothing stale shows once a driver turns on
      p9_out_o                   <= 8'h00;
      p9_oe_n_o                  <= 8'hFF;
      p10_out_o                  <= 8'h00;
      p10_oe_n_o                 <= 8'hFF;
      p11_out_o                  <= 8'h00;
      p11_oe_n_o                 <= 8'hFF;
      p12_out_o                  <= 2'b00;
      p12_oe_n_o                 <= 2'b11;
      p9_in_o                    <= 8'h00;
      p10_in_o                   <= 8'h00;
      p11_monitor_en_o           <= 1'b0;
    end else begin
      p9_data                    <= next_p9_data;
      p9_direction               <= next_p9_direction;
      port9_alt_function_select  <= next_port9_alt_function_select;
      p10_data                   <= next_p10_data;
      p10_direction              <= next_p10_direction;
      port10_alt_function_select <= next_port10_alt_function_select;
      p11_data                   <= next_p11_data;
      port11_direction           <= next_port11_direction;
      p12_data                   <= next_p12_data;
      port12_direction           <= next_port12_direction;
      wb_ack_o                   <= next_ack;
      wb_dat_o                   <= next_dat;
      p9_out_o                   <= next_p9_pin.out;
      p9_oe_n_o                  <= next_p9_pin.oe_n;
      p10_out_o                  <= next_p10_pin.out;
      p10_oe_n_o                 <= next_p10_pin.oe_n;
      p11_out_o                  <= next_p11_pin.out;
      p11_oe_n_o                 <= next_p11_pin.oe_n;
      p12_out_o                  <= next_p12_out;
      p12_oe_n_o                 <= next_p12_oe_n;
      p9_in_o                    <= next_p9_in;
      p10_in_o                   <= next_p10_in;
      p11_monitor_en_o           <= next_mon_en;
    end
  end

endmodule : iopc_top

`default_nettype wire

/* File: sim/iopc_pin_model.sv */
// Board-side pin model: resolves each pad from the block's driver and the board level
`timescale 1ns/10ps
`default_nettype none
module iopc_pin_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] out_i,
  input  wire logic [W-1:0] oe_n_i,
  input  wire logic [W-1:0] ext_i,
  output logic      [W-1:0] pin_o
);
  // A released driver, gated or not, lets the board level through
  assign pin_o = (out_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule : iopc_pin_model
`default_nettype wire

/* File: sim/iopc_top_sva.sv */
// Concurrent checks on the ports of the upper-port pin control block
`timescale 1ns/10ps
`default_nettype none
module iopc_top_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  p9_pin_i,
  input wire logic [7:0]  p9_in_o,
  input wire logic [7:0]  p10_oe_n_o,
  input wire logic [1:0]  p12_oe_n_o,
  input wire logic [1:0]  p12_out_o,
  input wire logic        driver_gate_n_i,
  input wire logic        external_fetch_select_n_i,
  input wire logic [1:0]  ext_addr_hi_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A new request while the slave is idle
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Fetch and gate both low long enough to pass the synchronisers
  sequence s_fetch;
    (!external_fetch_select_n_i && !driver_gate_n_i && $stable(ext_addr_hi_i))[*4];
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_rd_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_reset_idle: assert property ($fell(rst_i) |-> &p10_oe_n_o && &p12_oe_n_o)
    else $error("driver on after reset");
  a_gate_off: assert property (driver_gate_n_i[*4] |-> &p10_oe_n_o[4:0] && &p12_oe_n_o)
    else $error("gated driver on");
  a_addr_out: assert property (s_fetch |-> !p12_oe_n_o[0] && p12_out_o[0] == ext_addr_hi_i[0])
    else $error("address bit not driven");
  a_pin_sync: assert property ($stable(p9_pin_i)[*4] |-> p9_in_o == p9_pin_i)
    else $error("pin input stale");
  a_addr_keep: assert property (external_fetch_select_n_i[*5] |-> $stable(p12_oe_n_o)
    || $past(wb_ack_o) || $past(driver_gate_n_i, 4) != driver_gate_n_i
    || !$stable(driver_gate_n_i))
    else $error("address drive outside fetch");
endmodule : iopc_top_sva
bind iopc_top iopc_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .p9_pin_i(p9_pin_i),
  .p9_in_o(p9_in_o), .p10_oe_n_o(p10_oe_n_o), .p12_oe_n_o(p12_oe_n_o), .p12_out_o(p12_out_o),
  .driver_gate_n_i(driver_gate_n_i), .external_fetch_select_n_i(external_fetch_select_n_i),
  .ext_addr_hi_i(ext_addr_hi_i));
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the upper-port pin control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk_i, rst_i, cyc, stb, we, ack, gate_n, fetch_n, wide, capture, expo, mon_en;
  logic [7:0]  adr, p9_pin, p10_pin, p11_pin, p9_out, p10_out, p11_out, p9_in, p10_in, v;
  logic [7:0]  p9_oe_n, p10_oe_n, p11_oe_n, e9, e10, e11; // e*: board level on free pins
  logic [1:0]  p12_pin, p12_out, p12_oe_n, e12, addr_hi;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q; // q: read data taken at the ack edge
  int          n_mismatch, tests_run;
  iopc_pkg::iopc_periph_t pr9, pr10, mon11;
  iopc_top u_iopc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .p9_pin_i(p9_pin), .p10_pin_i(p10_pin), .p11_pin_i(p11_pin),
    .p12_pin_i(p12_pin), .p9_out_o(p9_out), .p9_oe_n_o(p9_oe_n), .p10_out_o(p10_out),
    .p10_oe_n_o(p10_oe_n), .p11_out_o(p11_out), .p11_oe_n_o(p11_oe_n),
    .p12_out_o(p12_out), .p12_oe_n_o(p12_oe_n), .driver_gate_n_i(gate_n),
    .external_fetch_select_n_i(fetch_n), .wide_address_i(wide), .p9_periph_i(pr9),
    .p10_periph_i(pr10), .p11_monitor_i(mon11), .ext_addr_hi_i(addr_hi),
    .capture_mode_i(capture), .expansion_out_mode_i(expo), .p9_in_o(p9_in),
    .p10_in_o(p10_in), .p11_monitor_en_o(mon_en));
  iopc_pin_model #(.W(8)) u_pin9 (.out_i(p9_out), .oe_n_i(p9_oe_n), .ext_i(e9), .pin_o(p9_pin));
  iopc_pin_model #(.W(8)) u_pin10 (.out_i(p10_out), .oe_n_i(p10_oe_n), .ext_i(e10), .pin_o(p10_pin));
  iopc_pin_model #(.W(8)) u_pin11 (.out_i(p11_out), .oe_n_i(p11_oe_n), .ext_i(e11), .pin_o(p11_pin));
  iopc_pin_model #(.W(2)) u_pin12 (.out_i(p12_out), .oe_n_i(p12_oe_n), .ext_i(e12), .pin_o(p12_pin));
  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task print_verdict();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  // Classic single cycle; held until ack is seen, so an answer within 19 cycles is fine
  task wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 20) begin
      chk(32'h0000_0000, 32'h0000_0001, "ack timeout");
      print_verdict();
    end
  endtask : wb
  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  // Every word, the unmapped one too, reads zero; no driver on
  task t_reset();
    for (int i = 0; i < 12; i++) begin
      wb(8'(i * 4), 1'b0, 8'h00);
      chk(q, 32'h0000_0000, "reset read");
    end
    chk(32'({p9_oe_n, p10_oe_n, p11_oe_n, p12_oe_n}), 32'h03FF_FFFF, "reset drive");
    $display("test reset done");
  endtask : t_reset
  // Mixed direction, read-back by direction, then a modify-write that lands in the latch
  task t_plain();
    logic [7:0] d, m, oe;
    logic [7:0] ofs [4];
    ofs = '{iopc_pkg::P9_DATA_OFS, iopc_pkg::P10_DATA_OFS, iopc_pkg::P11_DATA_OFS,
      iopc_pkg::P12_DATA_OFS};
    {e9, e10, e11, e12} <= {8'h3E, 8'h3E, 8'h3E, 2'b10};
    for (int k = 0; k < 4; k++) begin
      d = ofs[k];
      m = (k == 3) ? 8'h03 : 8'hFF;
      wb(d, 1'b1, 8'hA5);
      wb(d + 8'h04, 1'b1, 8'h05);
      wt(4);
      oe = (k == 0) ? p9_oe_n : (k == 1) ? p10_oe_n : (k == 2) ? p11_oe_n : {6'h3F, p12_oe_n};
      chk(32'(oe), {24'h00_0000, ~(8'h05 & m)}, "direction");
      wb(d, 1'b0, 8'h00);
      chk(q, 32'(8'h3F & m), "plain read");
      v = q[7:0] | 8'h80;
      wb(d, 1'b1, v);
      wb(d + 8'h04, 1'b1, 8'hFF);
      wb(d, 1'b0, 8'h00);
      chk(q, 32'(v & m), "modify write");
      wb(d + 8'h04, 1'b1, 8'h00);
    end
    $display("test plain done");
  endtask : t_plain
  // Secondary functions: peripheral drive and the per-bit read-back choices
  task t_alt();
    logic [7:0] sm;
    pr9 <= '{out_data: 8'h5A, out_en: 8'hC3};
    pr10 <= '{out_data: 8'h96, out_en: 8'h00};
    e10 <= 8'hC3;
    wb(iopc_pkg::P9_ALT_OFS, 1'b1, 8'hFF);
    wb(iopc_pkg::P10_ALT_OFS, 1'b1, 8'hFF);
    wt(4);
    chk(32'(p9_oe_n), 32'h0000_003C, "alt drive");
    chk(32'({p9_out & 8'hC3, p9_in}), 32'h0000_427E, "alt data");
    for (int c = 0; c < 4; c++) begin
      {expo, capture} <= 2'(c);
      wt(3);
      wb(iopc_pkg::P10_DATA_OFS, 1'b0, 8'h00);
      sm = 8'hA3 | (c[0] ? 8'h00 : 8'h10) | (c[1] ? 8'h40 : 8'h00);
      chk(q, 32'((8'h96 & sm) | (8'hC3 & ~sm)), "alt read");
    end
    wb(iopc_pkg::P9_ALT_OFS, 1'b1, 8'h00);
    wb(iopc_pkg::P10_ALT_OFS, 1'b1, 8'h00);
    $display("test alt done");
  endtask : t_alt
  // Global gate: listed drivers off, inputs still read, level visible in bit 7
  task t_gate();
    wb(iopc_pkg::P10_DATA_OFS, 1'b1, 8'hFF);
    wb(iopc_pkg::P10_DIR_OFS, 1'b1, 8'hF0);
    wb(iopc_pkg::P12_DIR_OFS, 1'b1, 8'h03);
    for (int g = 1; g >= 0; g--) begin
      gate_n <= g[0];
      wt(5);
      chk(32'({p12_oe_n, p10_oe_n}), g ? 32'h0000_031F : 32'h0000_000F, "gate");
      wb(iopc_pkg::P10_DATA_OFS, 1'b0, 8'h00);
      chk(q, 32'h0000_00F3, "gated input");
      wb(iopc_pkg::PERIPH_CTL_OFS, 1'b0, 8'h00);
      chk(q, g ? 32'h0000_0080 : 32'h0000_0000, "gate level");
      chk(32'({p10_out, p10_in}), g ? 32'h0000_FFE3 : 32'h0000_FFF3, "gated pins");
    end
    wb(iopc_pkg::P12_DIR_OFS, 1'b1, 8'h00);
    $display("test gate done");
  endtask : t_gate
  // Fetch select: monitor only when high, address drive on port 12 when low
  task t_fetch();
    mon11 <= '{out_data: 8'h05, out_en: 8'h0F};
    addr_hi <= 2'b11;
    wt(4);
    chk(32'({mon_en, p11_oe_n, p11_out[3:0]}), 32'h0000_1F05, "monitor");
    fetch_n <= 1'b0;
    wt(5);
    chk(32'({mon_en, p11_oe_n, p12_oe_n, p12_out[0]}), 32'h0000_07FD, "fetch");
    wide <= 1'b1;
    wt(4);
    chk(32'({p12_oe_n, p12_out}), 32'h0000_0003, "wide address");
    {fetch_n, wide} <= 2'b10;
    $display("test fetch done");
  endtask : t_fetch
  initial begin
    {rst_i, cyc, stb, we, gate_n, fetch_n, wide, capture, expo} = 9'h108; // Reset on, fetch high
    {adr, sel, wdat, e9, e10, e11, e12, addr_hi} = {8'h00, 4'h1, 32'h0000_0000, 28'h000_0000};
    {pr9, pr10, mon11} = 48'h0000_0000_0000;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_plain();
    t_alt();
    t_gate();
    t_fetch();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
